// *** common/ccmode_pkg.sv ***
// Package for the two-channel capture/compare mode block: offsets, fields, resets, modes.
// Assumes an APB slave with 32-bit data and one aligned word per register.
// Functional notes
// (RL1) Channel 2 direction: 00 output, 01 input two, 10 input one, 11 internal trigger.
// (RL2) Direction fields accept writes only while their channel is switched off.
// (RL3) Channel 2 internal-trigger capture works only when trigger select picks internal.
// (RL4) Clear-enable set lets an active external trigger level clear the channel 1 reference.
// (RL5) Three-bit mode drives active-high reference; outputs follow their own polarity bits.
// (RL6) Mode 000 frozen: comparisons leave the reference unchanged.
// (RL7) Mode 001 drives reference high on counter equal compare value.
// (RL8) Mode 010 drives reference low on counter equal compare value.
// (RL9) Mode 011 toggles reference on each counter equal compare value.
// (RL10) Mode 100 forces reference low, mode 101 forces it high.
// (RL11) PWM one: up high below compare; down low above compare, else high.
// (RL12) PWM two: up low below compare, else high; down chosen as mirror.
// (RL13) Mode field writes ignored while lock engaged and channel is an output.
// (RL14) PWM reference changes only on compare result change or leaving frozen mode.
// (RL15) Channel 2 preload and fast-response bits act like channel 1 ones.
// (RL16) Preload off: compare write immediate; on: transferred at update event.
// (RL17) Fast response in PWM: trigger edge counts as match, forcing compare level.
// (RL18) Write protection applies when lock level equals 3 and channel is output.
// (RL19) Channel 2 reference uses same eight modes with its own compare register.
package ccmode_pkg;

  localparam logic [11:0] MODE_OFFSET    = 12'h000;
  localparam logic [11:0] CMP1_OFFSET    = 12'h004;
  localparam logic [11:0] CMP2_OFFSET    = 12'h008;
  localparam logic [11:0] CTRL_OFFSET    = 12'h00C;
  localparam logic [11:0] STATUS_OFFSET  = 12'h010;

  localparam logic [15:0] MODE_RESET     = 16'h0000;
  localparam logic [15:0] CMP_RESET      = 16'h0000;
  localparam logic [1:0]  LOCK_PROTECT   = 2'h3;
  localparam logic [1:0]  DIR_OUTPUT     = 2'h0;
  localparam logic [1:0]  DIR_TRIGGER    = 2'h3;

  // Field positions inside the mode register
  localparam int CH2_CLEAR_POS   = 15;
  localparam int CH2_MODE_LSB    = 12;
  localparam int CH2_PRELOAD_POS = 11;
  localparam int CH2_FAST_POS    = 10;
  localparam int CH2_DIR_LSB     = 8;
  localparam int CH1_CLEAR_POS   = 7;
  localparam int CH1_MODE_LSB    = 4;
  localparam int CH1_PRELOAD_POS = 3;
  localparam int CH1_FAST_POS    = 2;
  localparam int CH1_DIR_LSB     = 0;

  // Control register positions
  localparam int CTRL_EN1_POS    = 0;
  localparam int CTRL_EN2_POS    = 1;
  localparam int CTRL_POL1_POS   = 2;
  localparam int CTRL_NPOL1_POS  = 3;
  localparam int CTRL_POL2_POS   = 4;
  localparam int CTRL_LOCK_LSB   = 8;
  localparam int CTRL_TRIGINT_POS = 10;
  localparam logic [10:0] CTRL_RESET = 11'h000;

  typedef enum logic [2:0] {
    MODE_FROZEN = 3'h0,
    MODE_SET    = 3'h1,
    MODE_CLEAR  = 3'h2,
    MODE_TOGGLE = 3'h3,
    MODE_LOW    = 3'h4,
    MODE_HIGH   = 3'h5,
    MODE_PWM1   = 3'h6,
    MODE_PWM2   = 3'h7
  } cmp_mode_t;

  typedef struct packed {
    logic [15:0] count;
    logic        countDown;
    logic        update;
    logic        trigEdge;
  } timer_in_t;

  typedef struct packed {
    logic [1:0] captureSel1;
    logic [1:0] captureSel2;
    logic       ref1;
    logic       ref2;
    logic       out1;
    logic       out1N;
    logic       out2;
  } cc_out_t;

endpackage : ccmode_pkg

// *** hw/ccmode_core.sv ***
// Capture/compare mode control for channels 1 and 2 with APB register access.
// Assumes counter, direction, update and trigger-edge arrive from same-clock timer logic;
// the external clear pin is asynchronous and is synchronised here.
module ccmode_core
  import ccmode_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire timer_in_t   timerIn,
  input  wire logic        extTrigPin,
  output cc_out_t          ccOut
);

  logic [15:0] mode_reg;
  logic [10:0] ctrl_reg;
  logic [15:0] cmpShadow_reg [2];
  logic [15:0] cmpActive_reg [2];
  logic [1:0]  ref_reg;
  logic [1:0]  cmpLess_reg;
  logic [1:0]  frozenPrev_reg;
  logic [2:0]  extSync_reg;
  logic        extLevel_reg;
  cc_out_t     ccOut_reg;

  logic        wrEn;
  logic        lockOn;
  logic [15:0] mode_next;

  function automatic logic isPwm(input logic [2:0] m);
    return m[2] & m[1];
  endfunction : isPwm

  function automatic logic pwmLevel(input logic [2:0] m, input logic dn,
                                    input logic [15:0] c, input logic [15:0] r);
    logic lvl;
    lvl = dn ? !(c > r) : (c < r);
    return (m == MODE_PWM1) ? lvl : !lvl;
  endfunction : pwmLevel

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wrEn    = psel & penable & pwrite & clkEn;
  assign lockOn  = ctrl_reg[CTRL_LOCK_LSB +: 2] == LOCK_PROTECT;

  always_comb begin
    mode_next = mode_reg;
    mode_next[CH1_CLEAR_POS] = pwdata[CH1_CLEAR_POS];
    mode_next[CH2_CLEAR_POS] = pwdata[CH2_CLEAR_POS];
    if (!(lockOn && mode_reg[CH1_DIR_LSB +: 2] == DIR_OUTPUT)) begin // [RL13] [RL18]
      mode_next[CH1_MODE_LSB +: 3] = pwdata[CH1_MODE_LSB +: 3];
      mode_next[CH1_PRELOAD_POS]   = pwdata[CH1_PRELOAD_POS];
      mode_next[CH1_FAST_POS]      = pwdata[CH1_FAST_POS];
    end
    if (!(lockOn && mode_reg[CH2_DIR_LSB +: 2] == DIR_OUTPUT)) begin // [RL18]
      mode_next[CH2_MODE_LSB +: 3] = pwdata[CH2_MODE_LSB +: 3];
      mode_next[CH2_PRELOAD_POS]   = pwdata[CH2_PRELOAD_POS]; // [RL15]
      mode_next[CH2_FAST_POS]      = pwdata[CH2_FAST_POS]; // [RL15]
    end
    if (!ctrl_reg[CTRL_EN1_POS]) begin // [RL2]
      mode_next[CH1_DIR_LSB +: 2] = pwdata[CH1_DIR_LSB +: 2];
    end
    if (!ctrl_reg[CTRL_EN2_POS]) begin // [RL2]
      mode_next[CH2_DIR_LSB +: 2] = pwdata[CH2_DIR_LSB +: 2];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= MODE_RESET;
    end else if (wrEn && paddr == MODE_OFFSET) begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wrEn && paddr == CTRL_OFFSET) begin
      ctrl_reg <= pwdata[10:0];
    end
  end

  // Shadow holds software value; active copy is what the comparator sees
  for (genvar ch = 0; ch < 2; ch++) begin : gChan
    localparam int PL = (ch == 0) ? CH1_PRELOAD_POS : CH2_PRELOAD_POS;
    localparam int ML = (ch == 0) ? CH1_MODE_LSB : CH2_MODE_LSB;
    localparam int FP = (ch == 0) ? CH1_FAST_POS : CH2_FAST_POS;
    localparam int CP = (ch == 0) ? CH1_CLEAR_POS : CH2_CLEAR_POS;
    localparam logic [11:0] OFS = (ch == 0) ? CMP1_OFFSET : CMP2_OFFSET;
    logic        wrCmp;
    logic [2:0]  m;
    logic        match;
    logic        less;
    logic        lvl;
    assign wrCmp = wrEn && paddr == OFS;
    assign m     = mode_reg[ML +: 3];
    assign match = timerIn.count == cmpActive_reg[ch];
    // Raw comparison kept apart from the mode, so a PWM1/PWM2 swap alone moves nothing
    assign less  = pwmLevel(MODE_PWM1, timerIn.countDown, timerIn.count, cmpActive_reg[ch]);
    assign lvl   = pwmLevel(m, timerIn.countDown, timerIn.count, cmpActive_reg[ch]);

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        cmpShadow_reg[ch] <= CMP_RESET;
        cmpActive_reg[ch] <= CMP_RESET;
      end else if (clkEn) begin
        if (wrCmp) begin
          cmpShadow_reg[ch] <= pwdata[15:0];
        end
        if (wrCmp && !mode_reg[PL]) begin
          cmpActive_reg[ch] <= pwdata[15:0]; // [RL16]
        end else if (mode_reg[PL] && timerIn.update) begin
          cmpActive_reg[ch] <= cmpShadow_reg[ch]; // [RL16] [RL15]
        end
      end
    end

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        ref_reg[ch]        <= 1'b0;
        cmpLess_reg[ch]    <= 1'b0;
        frozenPrev_reg[ch] <= 1'b1;
      end else if (clkEn) begin
        cmpLess_reg[ch]    <= less;
        frozenPrev_reg[ch] <= m == MODE_FROZEN;
        if (mode_reg[CP] && extLevel_reg) begin
          ref_reg[ch] <= 1'b0; // [RL4]
        end else begin
          case (m) // [RL5] [RL19]
            MODE_FROZEN: ref_reg[ch] <= ref_reg[ch]; // [RL6]
            MODE_SET:    if (match) ref_reg[ch] <= 1'b1; // [RL7]
            MODE_CLEAR:  if (match) ref_reg[ch] <= 1'b0; // [RL8]
            MODE_TOGGLE: if (match) ref_reg[ch] <= !ref_reg[ch]; // [RL9]
            MODE_LOW:    ref_reg[ch] <= 1'b0; // [RL10]
            MODE_HIGH:   ref_reg[ch] <= 1'b1; // [RL10]
            MODE_PWM1, MODE_PWM2: begin
              // Fast response lets a trigger edge act as a match ahead of the compare
              if (mode_reg[FP] && timerIn.trigEdge) begin
                ref_reg[ch] <= (m == MODE_PWM1); // [RL17]
              end else if (less != cmpLess_reg[ch] || frozenPrev_reg[ch]) begin
                ref_reg[ch] <= lvl; // [RL11] [RL12] [RL14]
              end
            end
            default:     ref_reg[ch] <= ref_reg[ch];
          endcase
        end
      end
    end
  end

  // Only the agreeing second and third stages are looked at
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      extSync_reg  <= 3'h0;
      extLevel_reg <= 1'b0;
    end else if (clkEn) begin
      extSync_reg <= {extSync_reg[1:0], extTrigPin};
      if (extSync_reg[1] == extSync_reg[2]) begin
        extLevel_reg <= extSync_reg[2];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ccOut_reg <= '0;
    end else if (clkEn) begin
      ccOut_reg.captureSel1 <= mode_reg[CH1_DIR_LSB +: 2];
      // Internal trigger mapping is meaningless unless the slave picks an internal input
      if (mode_reg[CH2_DIR_LSB +: 2] == DIR_TRIGGER && !ctrl_reg[CTRL_TRIGINT_POS]) begin
        ccOut_reg.captureSel2 <= DIR_OUTPUT; // [RL3]
      end else begin
        ccOut_reg.captureSel2 <= mode_reg[CH2_DIR_LSB +: 2]; // [RL1]
      end
      ccOut_reg.ref1  <= ref_reg[0];
      ccOut_reg.ref2  <= ref_reg[1];
      ccOut_reg.out1  <= ref_reg[0] ^ ctrl_reg[CTRL_POL1_POS]; // [RL5]
      ccOut_reg.out1N <= !ref_reg[0] ^ ctrl_reg[CTRL_NPOL1_POS]; // [RL5]
      ccOut_reg.out2  <= ref_reg[1] ^ ctrl_reg[CTRL_POL2_POS];
    end
  end
  assign ccOut = ccOut_reg;

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      MODE_OFFSET:   prdata = {16'h0000, mode_reg};
      CMP1_OFFSET:   prdata = {16'h0000, cmpShadow_reg[0]};
      CMP2_OFFSET:   prdata = {16'h0000, cmpShadow_reg[1]};
      CTRL_OFFSET:   prdata = {21'h0, ctrl_reg};
      STATUS_OFFSET: prdata = {29'h0, extLevel_reg, ref_reg};
      default:       prdata = 32'h0000_0000;
    endcase
  end

  AST_MODE_LOW: assert property (@(posedge clock) disable iff (!arst_n) // [RL10]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_LOW |=> !ref_reg[0])
    else $error("forced low mode left reference high");

  AST_MODE_HIGH: assert property (@(posedge clock) disable iff (!arst_n) // [RL10]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_HIGH && !(mode_reg[CH1_CLEAR_POS] && extLevel_reg)
    |=> ref_reg[0])
    else $error("forced high mode left reference low");

  AST_FROZEN: assert property (@(posedge clock) disable iff (!arst_n) // [RL6]
    mode_reg[CH1_MODE_LSB +: 3] == MODE_FROZEN && !(mode_reg[CH1_CLEAR_POS] && extLevel_reg)
    |=> $stable(ref_reg[0]))
    else $error("frozen reference changed");

  AST_SET_MATCH: assert property (@(posedge clock) disable iff (!arst_n) // [RL7]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_SET && gChan[0].match && !extLevel_reg
    |=> ref_reg[0])
    else $error("match did not set reference");

  AST_CLR_MATCH: assert property (@(posedge clock) disable iff (!arst_n) // [RL8]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_CLEAR && gChan[0].match |=> !ref_reg[0])
    else $error("match did not clear reference");

  AST_TOGGLE: assert property (@(posedge clock) disable iff (!arst_n) // [RL9]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_TOGGLE && gChan[0].match && !extLevel_reg
    |=> ref_reg[0] != $past(ref_reg[0]))
    else $error("match did not toggle reference");

  AST_EXT_CLEAR: assert property (@(posedge clock) disable iff (!arst_n) // [RL4]
    clkEn && mode_reg[CH1_CLEAR_POS] && extLevel_reg |=> !ref_reg[0])
    else $error("external clear ignored");

  AST_DIR_LOCK: assert property (@(posedge clock) disable iff (!arst_n) // [RL2]
    ctrl_reg[CTRL_EN1_POS] |=> mode_reg[1:0] == $past(mode_reg[1:0]))
    else $error("direction changed while channel on");

  AST_MODE_LOCK: assert property (@(posedge clock) disable iff (!arst_n) // [RL13]
    lockOn && mode_reg[1:0] == DIR_OUTPUT |=> $stable(mode_reg[6:4]))
    else $error("locked mode field changed");

  AST_PRELOAD: assert property (@(posedge clock) disable iff (!arst_n) // [RL16]
    clkEn && !mode_reg[CH1_PRELOAD_POS] && wrEn && paddr == CMP1_OFFSET
    |=> cmpActive_reg[0] == $past(pwdata[15:0]))
    else $error("immediate compare write lost");

  AST_PRELOAD_HOLD: assert property (@(posedge clock) disable iff (!arst_n) // [RL16]
    mode_reg[CH1_PRELOAD_POS] && !timerIn.update |=> $stable(cmpActive_reg[0]))
    else $error("preloaded compare value moved without update");

  AST_PRELOAD_UPD: assert property (@(posedge clock) disable iff (!arst_n) // [RL16]
    clkEn && mode_reg[CH1_PRELOAD_POS] && timerIn.update
    |=> cmpActive_reg[0] == $past(cmpShadow_reg[0]))
    else $error("update event did not load compare value");

  AST_CH2_PRELOAD: assert property (@(posedge clock) disable iff (!arst_n) // [RL15]
    mode_reg[CH2_PRELOAD_POS] && !timerIn.update |=> $stable(cmpActive_reg[1]))
    else $error("channel 2 preload ignored");

  AST_PWM1_UP: assert property (@(posedge clock) disable iff (!arst_n) // [RL11]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_PWM1 && !timerIn.countDown
    && timerIn.count < cmpActive_reg[0] && !cmpLess_reg[0]
    && !(mode_reg[CH1_CLEAR_POS] && extLevel_reg) |=> ref_reg[0])
    else $error("pwm one up count left reference low");

  AST_PWM1_UP_LOW: assert property (@(posedge clock) disable iff (!arst_n) // [RL11]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_PWM1 && !timerIn.countDown
    && timerIn.count >= cmpActive_reg[0] && cmpLess_reg[0]
    && !(mode_reg[CH1_FAST_POS] && timerIn.trigEdge) |=> !ref_reg[0])
    else $error("pwm one up count left reference high");

  AST_PWM1_DOWN: assert property (@(posedge clock) disable iff (!arst_n) // [RL11]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_PWM1 && timerIn.countDown
    && timerIn.count > cmpActive_reg[0] && cmpLess_reg[0]
    && !(mode_reg[CH1_FAST_POS] && timerIn.trigEdge) |=> !ref_reg[0])
    else $error("pwm one down count left reference high");

  AST_PWM2_UP: assert property (@(posedge clock) disable iff (!arst_n) // [RL12]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_PWM2 && !timerIn.countDown
    && timerIn.count < cmpActive_reg[0] && !cmpLess_reg[0] |=> !ref_reg[0])
    else $error("pwm two up count left reference high");

  AST_PWM2_UP_HIGH: assert property (@(posedge clock) disable iff (!arst_n) // [RL12]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_PWM2 && !timerIn.countDown
    && timerIn.count >= cmpActive_reg[0] && cmpLess_reg[0]
    && !(mode_reg[CH1_FAST_POS] && timerIn.trigEdge)
    && !(mode_reg[CH1_CLEAR_POS] && extLevel_reg) |=> ref_reg[0])
    else $error("pwm two up count left reference low");

  AST_PWM_ENTRY: assert property (@(posedge clock) disable iff (!arst_n) // [RL14]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_PWM1 && frozenPrev_reg[0] && !timerIn.countDown
    && timerIn.count < cmpActive_reg[0] && !(mode_reg[CH1_CLEAR_POS] && extLevel_reg)
    |=> ref_reg[0])
    else $error("reference not refreshed on leaving frozen mode");

  AST_PWM_HOLD: assert property (@(posedge clock) disable iff (!arst_n) // [RL14]
    clkEn && isPwm(mode_reg[CH1_MODE_LSB +: 3]) && !frozenPrev_reg[0]
    && gChan[0].less == cmpLess_reg[0] && !(mode_reg[CH1_FAST_POS] && timerIn.trigEdge)
    && !(mode_reg[CH1_CLEAR_POS] && extLevel_reg) |=> $stable(ref_reg[0]))
    else $error("pwm reference moved without a comparison change");

  AST_FAST_PWM1: assert property (@(posedge clock) disable iff (!arst_n) // [RL17]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_PWM1 && mode_reg[CH1_FAST_POS] && timerIn.trigEdge
    && !(mode_reg[CH1_CLEAR_POS] && extLevel_reg) |=> ref_reg[0])
    else $error("fast trigger did not force pwm one level");

  AST_FAST_PWM2: assert property (@(posedge clock) disable iff (!arst_n) // [RL17]
    clkEn && mode_reg[CH1_MODE_LSB +: 3] == MODE_PWM2 && mode_reg[CH1_FAST_POS] && timerIn.trigEdge
    |=> !ref_reg[0])
    else $error("fast trigger did not force pwm two level");

  AST_EXT_OFF: assert property (@(posedge clock) disable iff (!arst_n) // [RL4]
    clkEn && !mode_reg[CH1_CLEAR_POS] && extLevel_reg
    && mode_reg[CH1_MODE_LSB +: 3] == MODE_HIGH |=> ref_reg[0])
    else $error("disabled external clear still acted");

  AST_CAPSEL2: assert property (@(posedge clock) disable iff (!arst_n) // [RL1]
    clkEn && (mode_reg[CH2_DIR_LSB +: 2] != DIR_TRIGGER || ctrl_reg[CTRL_TRIGINT_POS])
    |=> ccOut_reg.captureSel2 == $past(mode_reg[CH2_DIR_LSB +: 2]))
    else $error("channel 2 capture selection not applied");

  AST_TRIG_GATE: assert property (@(posedge clock) disable iff (!arst_n) // [RL3]
    clkEn && mode_reg[CH2_DIR_LSB +: 2] == DIR_TRIGGER && !ctrl_reg[CTRL_TRIGINT_POS]
    |=> ccOut_reg.captureSel2 != DIR_TRIGGER)
    else $error("internal trigger capture used without internal trigger select");

  AST_OUT_POL: assert property (@(posedge clock) disable iff (!arst_n) // [RL5]
    clkEn |=> ccOut_reg.out1 == ($past(ref_reg[0]) ^ $past(ctrl_reg[CTRL_POL1_POS])))
    else $error("true output polarity wrong");

  AST_OUTN_POL: assert property (@(posedge clock) disable iff (!arst_n) // [RL5]
    clkEn |=> ccOut_reg.out1N == (!$past(ref_reg[0]) ^ $past(ctrl_reg[CTRL_NPOL1_POS])))
    else $error("complementary output polarity wrong");

  AST_CH2_SET: assert property (@(posedge clock) disable iff (!arst_n) // [RL19]
    clkEn && mode_reg[CH2_MODE_LSB +: 3] == MODE_SET && gChan[1].match
    && !(mode_reg[CH2_CLEAR_POS] && extLevel_reg) |=> ref_reg[1])
    else $error("channel 2 match did not set reference");

  AST_CH2_LOW: assert property (@(posedge clock) disable iff (!arst_n) // [RL19]
    clkEn && mode_reg[CH2_MODE_LSB +: 3] == MODE_LOW |=> !ref_reg[1])
    else $error("channel 2 forced low mode left reference high");

  AST_DIR2_LOCK: assert property (@(posedge clock) disable iff (!arst_n) // [RL2]
    ctrl_reg[CTRL_EN2_POS] |=> $stable(mode_reg[CH2_DIR_LSB +: 2]))
    else $error("channel 2 direction changed while channel on");

  AST_MODE2_LOCK: assert property (@(posedge clock) disable iff (!arst_n) // [RL18]
    lockOn && mode_reg[CH2_DIR_LSB +: 2] == DIR_OUTPUT
    |=> $stable(mode_reg[CH2_MODE_LSB +: 3]))
    else $error("locked channel 2 mode field changed");

endmodule : ccmode_core

// *** verif/ccmode_core_tb.sv ***
// Self-checking bench for the channel 1/2 compare mode block.
// Assumes ccmode_pkg offsets, a zero-wait APB slave and clock enable high outside its freeze test.
module ccmode_core_tb
  import ccmode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock;
  logic        arst_n;
  logic        clkEn;
  logic        pslverr;
  logic        slvErr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  timer_in_t   timerIn;
  logic        extTrigPin;
  cc_out_t     ccOut;
  logic [31:0] q;
  int          failures;
  int          n_checks;

  ccmode_core uut (.clock(clock), .arst_n(arst_n), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timerIn(timerIn), .extTrigPin(extTrigPin),
    .ccOut(ccOut));

  always #50 clock = ~clock;

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkReg

  task automatic chkRef(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkRef

  // Request held until pready is seen high; the bound stops a silent slave hanging the run
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    {psel, penable, pwrite} <= {1'b1, 1'b0, wr};
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      failures++;
      test_done();
    end
    q = prdata;
    slvErr = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chkReg(q, exp);
  endtask : rd

  // Outputs are looked at on the falling edge, clear of the register updates
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : settle

  task automatic cnt(input logic [15:0] c);
    @(posedge clock);
    timerIn.count <= c;
  endtask : cnt

  task automatic hit(input logic [15:0] c);
    cnt(c);
    cnt(16'h0000);
    settle(3);
  endtask : hit

  task automatic modeRef(input logic [31:0] m, input logic exp);
    wr(MODE_OFFSET, m);
    settle(3);
    chkRef(ccOut.ref1, exp);
  endtask : modeRef

  task automatic cntRef(input logic [15:0] c, input logic exp);
    cnt(c);
    settle(3);
    chkRef(ccOut.ref1, exp);
  endtask : cntRef

  task automatic strobe(input logic upd);
    @(posedge clock);
    timerIn.update <= upd;
    timerIn.trigEdge <= !upd;
    @(posedge clock);
    {timerIn.update, timerIn.trigEdge} <= 2'h0;
  endtask : strobe

  task automatic ext(input logic v, input logic exp);
    @(posedge clock);
    extTrigPin <= v;
    settle(8);
    chkRef(ccOut.ref1, exp);
  endtask : ext

  task automatic pol(input logic [31:0] c, input logic e1, input logic eN);
    wr(CTRL_OFFSET, c);
    settle(3);
    chkRef(ccOut.out1, e1);
    chkRef(ccOut.out1N, eN);
  endtask : pol

  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    clkEn = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    timerIn = '0;
    extTrigPin = 1'b0;
    failures = 0;
    n_checks = 0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    rd(MODE_OFFSET, 32'h0);
    rd(CTRL_OFFSET, 32'h0);
    wr(12'h020, 32'h0000FFFF);
    chkRef(slvErr, 1'b0);
    rd(12'h020, 32'h0);
    wr(MODE_OFFSET, 32'h300);
    settle(3);
    chkReg({30'h0, ccOut.captureSel2}, 32'h0);
    wr(CTRL_OFFSET, 32'h400);
    for (int i = 3; i >= 0; i--) begin
      wr(MODE_OFFSET, 32'(i) << 8);
      settle(3);
      chkReg({30'h0, ccOut.captureSel2}, 32'(i));
    end
    wr(CTRL_OFFSET, 32'h401);
    wr(MODE_OFFSET, 32'h1);
    rd(MODE_OFFSET, 32'h0);
    wr(CTRL_OFFSET, 32'h400);
    wr(MODE_OFFSET, 32'h1);
    rd(MODE_OFFSET, 32'h1);
    wr(CMP1_OFFSET, 32'h10);
    rd(CMP1_OFFSET, 32'h10);
    modeRef(32'h50, 1'b1);
    modeRef(32'h40, 1'b0);
    modeRef(32'h10, 1'b0);
    hit(16'h10);
    chkRef(ccOut.ref1, 1'b1);
    modeRef(32'h20, 1'b1);
    hit(16'h10);
    chkRef(ccOut.ref1, 1'b0);
    modeRef(32'h30, 1'b0);
    hit(16'h10);
    chkRef(ccOut.ref1, 1'b1);
    hit(16'h10);
    chkRef(ccOut.ref1, 1'b0);
    modeRef(32'h50, 1'b1);
    modeRef(32'h00, 1'b1);
    hit(16'h10);
    chkRef(ccOut.ref1, 1'b1);
    modeRef(32'h60, 1'b1);
    cntRef(16'h20, 1'b0);
    modeRef(32'h70, 1'b0);
    cntRef(16'h05, 1'b0);
    cntRef(16'h20, 1'b1);
    modeRef(32'h00, 1'b1);
    @(posedge clock);
    timerIn.countDown <= 1'b1;
    modeRef(32'h60, 1'b0);
    cntRef(16'h05, 1'b1);
    @(posedge clock);
    timerIn.countDown <= 1'b0;
    cntRef(16'h20, 1'b0);
    modeRef(32'h64, 1'b0);
    strobe(1'b0);
    settle(2);
    chkRef(ccOut.ref1, 1'b1);
    modeRef(32'hD0, 1'b1);
    ext(1'b1, 1'b0);
    ext(1'b0, 1'b1);
    modeRef(32'h50, 1'b1);
    ext(1'b1, 1'b1);
    rd(STATUS_OFFSET, 32'h5);
    ext(1'b0, 1'b1);
    pol(32'h405, 1'b0, 1'b0);
    pol(32'h40D, 1'b0, 1'b1);
    pol(32'h401, 1'b1, 1'b0);
    wr(CTRL_OFFSET, 32'h700);
    wr(MODE_OFFSET, 32'h40);
    rd(MODE_OFFSET, 32'h50);
    wr(CTRL_OFFSET, 32'h600);
    wr(MODE_OFFSET, 32'h40);
    rd(MODE_OFFSET, 32'h40);
    wr(CTRL_OFFSET, 32'h400);
    wr(MODE_OFFSET, 32'h41);
    wr(CTRL_OFFSET, 32'h700);
    wr(MODE_OFFSET, 32'h51);
    rd(MODE_OFFSET, 32'h51);
    settle(1);
    chkReg({30'h0, ccOut.captureSel1}, 32'h1);
    wr(CTRL_OFFSET, 32'h400);
    wr(MODE_OFFSET, 32'h0);
    wr(CMP2_OFFSET, 32'h40);
    wr(MODE_OFFSET, 32'h1800);
    wr(CMP2_OFFSET, 32'h30);
    hit(16'h30);
    chkRef(ccOut.ref2, 1'b0);
    strobe(1'b1);
    hit(16'h30);
    chkRef(ccOut.ref2, 1'b1);
    wr(MODE_OFFSET, 32'h4000);
    settle(3);
    chkRef(ccOut.ref2, 1'b0);
    chkRef(ccOut.out2, 1'b0);
    wr(CTRL_OFFSET, 32'h410);
    settle(3);
    chkRef(ccOut.out2, 1'b1);
    // Clock enable low must swallow the write and freeze the reference
    @(posedge clock);
    clkEn <= 1'b0;
    wr(MODE_OFFSET, 32'h5000);
    settle(3);
    chkRef(ccOut.ref2, 1'b0);
    rd(MODE_OFFSET, 32'h4000);
    @(posedge clock);
    clkEn <= 1'b1;
    settle(3);
    chkRef(ccOut.ref2, 1'b0);
    test_done();
  end
endmodule : ccmode_core_tb
